// *** pkg/stc_defines.svh ***
// constants for the serial trace capture block
`ifndef STC_DEFINES_SVH
`define STC_DEFINES_SVH
// capture store split
`define STC_DATA_BYTES 10'h38e
`define STC_DIR_BYTES 7'h72
// trigger count defaults
`define STC_DEF_PKT_N 16'h0001
`define STC_DEF_BYTE_M 16'h0004
// staging fifo shape and entry layout
`define STC_FIFO_DEPTH 8'h10
`define STC_FIFO_W 8'h0a
`define STC_F_RST 4'h9
`define STC_F_DIR 4'h8
// direction bit values
`define STC_DIR_RX 1'h0
`define STC_DIR_TX 1'h1
`endif

// *** pkg/stc_pkg.sv ***
// types shared by the serial trace capture block
package stc_pkg;
  typedef enum logic [1:0] {
    STC_PACKET_COUNT_OPCODE_CONDITION,
    STC_BYTE_COUNT_VALUE_CONDITION,
    STC_PACKET_THEN_BYTE_MODE,
    STC_BYTE_THEN_PACKET_MODE
  } stc_mode_t;
  typedef enum logic [2:0] {
    STC_S_OFF,
    STC_S_SRCH1,
    STC_S_SRCH2,
    STC_S_LOG,
    STC_S_DONE
  } stc_state_t;
endpackage : stc_pkg

// *** rtl/stc_fifo.sv ***
// staging fifo between the trigger front end and the capture store
`timescale 1ns/1ps
module stc_fifo #(
  parameter int W = 10,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output wire logic         in_ready,
  // drain side
  output wire logic         out_valid,
  output wire logic [W-1:0] out_data,
  input  wire logic         out_ready,
  // registered full flag
  output logic              full
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("stc_fifo depth must be a power of two");
  end
  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;
  wire [AW:0]    cnt_nxt = flush ? '0 : cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  // full is a flop so ready never depends on the pop of the same cycle
  assign in_ready  = ~full;
  assign out_valid = cnt_r != '0;
  assign out_data  = mem_r[rp_r];
  // pointers and occupancy
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      full  <= 1'b0;
    end
    else
    begin
      wp_r  <= flush ? '0 : wp_r + AW'(push);
      rp_r  <= flush ? '0 : rp_r + AW'(pop);
      cnt_r <= cnt_nxt;
      full  <= cnt_nxt == (AW+1)'(D);
    end
  end
  // storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
endmodule : stc_fifo

// *** rtl/stc_top.sv ***
// serial trace capture: trigger search, staging and capture store
`timescale 1ns/1ps
`include "stc_defines.svh"
// Notes on behaviour
// - the store is 1K: 114 bytes of direction bits and 910 bytes of logged data.
// - once triggered every received and transmitted byte is logged with its direction, except bytes that are dropped and set DROPPED.
// - logging stops when the data area is full and later traffic is not written.
// - the first entries logged are the packet or byte that satisfied the trigger.
// - loading a trigger also enables the unit so it starts searching at once.
// - the packet condition needs a count of received packets with an opcode, count defaulting to one.
// - with no opcode set every received packet counts toward the packet count.
// - the byte condition needs a count of bytes of a value in either direction, count defaulting to four.
// - with no byte value set every byte in either direction counts.
// - packet-then-byte fires only when the byte condition follows a met packet condition.
// - byte-then-packet fires only when the packet condition follows a met byte condition.
// - off stops tracing and leaves captured data intact and readable.
// - on resumes tracing with the most recently configured trigger.
// - reset erases captured data and re-arms the search for the configured trigger.
// - readout gives logged bytes in link order, except that a held tx byte follows rx bytes of later cycles, each with its direction.
module stc_top #(
  parameter int CNT_W      = 16,
  parameter int DATA_BYTES = `STC_DATA_BYTES,
  parameter int DIR_BYTES  = `STC_DIR_BYTES,
  parameter int FIFO_D     = `STC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             RST_N,
  // link traffic
  input  wire logic             RX_VALID,
  input  wire logic [7:0]       RX_DATA,
  input  wire logic             TX_VALID,
  input  wire logic [7:0]       TX_DATA,
  // framing from the protocol receiver
  input  wire logic             PKT_SOF,
  input  wire logic             PKT_EOP,
  input  wire logic [7:0]       PKT_OPCODE,
  // trigger configuration
  input  wire logic             CFG_LOAD,
  input  wire logic [1:0]       CFG_MODE,
  input  wire logic             CFG_PKT_N_SET,
  input  wire logic [CNT_W-1:0] CFG_PKT_N,
  input  wire logic             CFG_OP_SET,
  input  wire logic [7:0]       CFG_OP,
  input  wire logic             CFG_BYTE_M_SET,
  input  wire logic [CNT_W-1:0] CFG_BYTE_M,
  input  wire logic             CFG_VAL_SET,
  input  wire logic [7:0]       CFG_VAL,
  // commands
  input  wire logic             CMD_ON,
  input  wire logic             CMD_OFF,
  input  wire logic             CMD_RESET,
  // readout
  input  wire logic             RD_REQ,
  input  wire logic [9:0]       RD_IDX,
  output logic                  RD_VALID,
  output logic                  RD_HIT,
  output logic [7:0]            RD_DATA,
  output logic                  RD_DIR,
  // status
  output logic                  ARMED,
  output logic                  LOGGING,
  output logic                  TRIGGERED,
  output logic                  FULL,
  output logic [9:0]            LEVEL,
  output logic                  DROPPED,
  output logic                  FIFO_FULL
);
  localparam logic [9:0] DB = 10'(DATA_BYTES);
  if (DATA_BYTES > 1023 || DATA_BYTES > DIR_BYTES * 8 || CNT_W < 2) begin : g_chk
    $error("stc_top store or counter sizing not supported");
  end

  // count reaches its target on this hit; a target of zero behaves as one
  function automatic logic cnt_met(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] n);
    cnt_met = ({1'b0, cnt} + (CNT_W+1)'(1)) >= {1'b0, n};
  endfunction : cnt_met

  // configuration held from the last load
  stc_pkg::stc_mode_t mode_r;
  logic [CNT_W-1:0]   pkt_n_r;
  logic [CNT_W-1:0]   byte_m_r;
  logic               op_en_r;
  logic [7:0]         op_r;
  logic               val_en_r;
  logic [7:0]         val_r;
  // event lane
  logic               ev_v_r;
  logic               ev_dir_r;
  logic [7:0]         ev_data_r;
  logic               ev_sof_r;
  logic               ev_eop_r;
  logic [7:0]         ev_op_r;
  logic               hold_v_r;
  logic [7:0]         hold_d_r;
  // search state
  stc_pkg::stc_state_t st_r;
  stc_pkg::stc_state_t st_nxt;
  logic [CNT_W-1:0]   pcnt_r;
  logic [CNT_W-1:0]   bcnt_r;
  logic               spec_r;
  logic               logged_r;
  // store
  logic [7:0]         data_mem [DATA_BYTES];
  logic [7:0]         dir_mem [DIR_BYTES];
  logic [9:0]         wptr_r;

  // rx and tx share one event lane; a tx byte that meets rx waits in the hold until a cycle with no rx byte
  wire       tx_lost     = RX_VALID & hold_v_r & TX_VALID;
  wire       ev_v_nxt    = RX_VALID | hold_v_r | TX_VALID;
  wire [7:0] ev_data_nxt = RX_VALID ? RX_DATA : (hold_v_r ? hold_d_r : TX_DATA);
  wire       hold_v_nxt  = RX_VALID ? (hold_v_r | TX_VALID) : (hold_v_r & TX_VALID);
  wire [7:0] hold_d_nxt  = (TX_VALID & ~tx_lost) ? TX_DATA : hold_d_r;

  // serialise link bytes, rx first, so a held tx byte goes after rx bytes of later cycles
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ev_v_r    <= 1'b0;
      ev_dir_r  <= `STC_DIR_RX;
      ev_data_r <= 8'h00;
      ev_sof_r  <= 1'b0;
      ev_eop_r  <= 1'b0;
      ev_op_r   <= 8'h00;
      hold_v_r  <= 1'b0;
      hold_d_r  <= 8'h00;
    end
    else
    begin
      ev_v_r    <= ev_v_nxt;
      ev_dir_r  <= RX_VALID ? `STC_DIR_RX : `STC_DIR_TX;
      ev_data_r <= ev_data_nxt;
      ev_sof_r  <= RX_VALID & PKT_SOF;
      ev_eop_r  <= RX_VALID & PKT_EOP;
      ev_op_r   <= PKT_OPCODE;
      hold_v_r  <= hold_v_nxt;
      hold_d_r  <= hold_d_nxt;
    end
  end

  // command decode
  wire clear = CFG_LOAD | CMD_RESET;
  wire srch  = (st_r == stc_pkg::STC_S_SRCH1) | (st_r == stc_pkg::STC_S_SRCH2);
  wire m_pkt = mode_r == stc_pkg::STC_PACKET_COUNT_OPCODE_CONDITION;
  wire m_byt = mode_r == stc_pkg::STC_BYTE_COUNT_VALUE_CONDITION;
  wire m_pb  = mode_r == stc_pkg::STC_PACKET_THEN_BYTE_MODE;
  wire m_bp  = mode_r == stc_pkg::STC_BYTE_THEN_PACKET_MODE;

  // which condition the current phase looks for, and whether it is the last
  wire ph_pkt  = (st_r == stc_pkg::STC_S_SRCH1) ? (m_pkt | m_pb) : m_bp;
  wire ph_last = (st_r == stc_pkg::STC_S_SRCH2) | m_pkt | m_byt;

  // matching on the event lane
  wire pkt_hit  = ev_v_r & (ev_dir_r == `STC_DIR_RX) & ev_eop_r & (~op_en_r | ev_op_r == op_r);
  wire byte_hit = ev_v_r & (~val_en_r | ev_data_r == val_r);
  wire pkt_met  = pkt_hit & cnt_met(pcnt_r, pkt_n_r);
  wire byte_met = byte_hit & cnt_met(bcnt_r, byte_m_r);
  wire met      = srch & (ph_pkt ? pkt_met : byte_met);
  wire fire     = met & ph_last & ~CMD_OFF; // off in the same cycle wins over a trigger

  // phase counters restart on every phase change
  wire [CNT_W-1:0] pcnt_nxt = (clear | met | ~srch) ? '0 : pcnt_r + CNT_W'(ph_pkt & pkt_hit);
  wire [CNT_W-1:0] bcnt_nxt = (clear | met | ~srch) ? '0 : bcnt_r + CNT_W'(~ph_pkt & byte_hit);

  // a candidate packet is staged from its start, so a packet trigger logs it whole
  wire spec_ph   = srch & ph_last & ph_pkt;
  wire ev_rx     = ev_v_r & (ev_dir_r == `STC_DIR_RX);
  wire spec_push = spec_ph & ev_rx & (spec_r | ev_sof_r);
  wire log_push  = (st_r == stc_pkg::STC_S_LOG) & ev_v_r & ~FULL;
  wire trig_push = fire & ~ph_pkt;
  wire spec_nxt  = spec_ph & ~clear & (ev_rx & ev_sof_r & ~ev_eop_r | spec_r & ~(ev_rx & ev_eop_r));

  // fifo fill side; a restart mark rewinds the store to entry zero
  wire       f_in_v   = (log_push | spec_push | trig_push) & ~clear;
  wire       f_in_rst = trig_push | (spec_push & ev_sof_r);
  wire       f_in_rdy;
  wire       f_out_v;
  wire [9:0] f_out_d;
  wire       drop_set = (f_in_v & ~f_in_rdy) | tx_lost;

  // trace state; configuration or reset wins over off, off over on
  always_comb
  begin
    st_nxt = st_r;
    if (clear)
      st_nxt = stc_pkg::STC_S_SRCH1;
    else if (CMD_OFF)
      st_nxt = stc_pkg::STC_S_OFF;
    else if (CMD_ON && st_r == stc_pkg::STC_S_OFF)
      st_nxt = logged_r ? (FULL ? stc_pkg::STC_S_DONE : stc_pkg::STC_S_LOG) : stc_pkg::STC_S_SRCH1;
    else
    begin
      unique case (st_r)
        stc_pkg::STC_S_OFF:   st_nxt = st_r;
        stc_pkg::STC_S_SRCH1: st_nxt = met ? (ph_last ? stc_pkg::STC_S_LOG : stc_pkg::STC_S_SRCH2) : st_r;
        stc_pkg::STC_S_SRCH2: st_nxt = met ? stc_pkg::STC_S_LOG : st_r;
        stc_pkg::STC_S_LOG:   st_nxt = FULL ? stc_pkg::STC_S_DONE : st_r;
        stc_pkg::STC_S_DONE:  st_nxt = st_r;
      endcase
    end
  end

  // configuration latch; missing counts take their defaults
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode_r   <= stc_pkg::STC_PACKET_COUNT_OPCODE_CONDITION;
      pkt_n_r  <= CNT_W'(`STC_DEF_PKT_N);
      byte_m_r <= CNT_W'(`STC_DEF_BYTE_M);
      op_en_r  <= 1'b0;
      op_r     <= 8'h00;
      val_en_r <= 1'b0;
      val_r    <= 8'h00;
    end
    else if (CFG_LOAD)
    begin
      mode_r   <= stc_pkg::stc_mode_t'(CFG_MODE);
      pkt_n_r  <= CFG_PKT_N_SET ? CFG_PKT_N : CNT_W'(`STC_DEF_PKT_N);
      byte_m_r <= CFG_BYTE_M_SET ? CFG_BYTE_M : CNT_W'(`STC_DEF_BYTE_M);
      op_en_r  <= CFG_OP_SET;
      op_r     <= CFG_OP;
      val_en_r <= CFG_VAL_SET;
      val_r    <= CFG_VAL;
    end
  end

  // search state and status flags
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_r      <= stc_pkg::STC_S_OFF;
      pcnt_r    <= '0;
      bcnt_r    <= '0;
      spec_r    <= 1'b0;
      logged_r  <= 1'b0;
      ARMED     <= 1'b0;
      LOGGING   <= 1'b0;
      TRIGGERED <= 1'b0;
      DROPPED   <= 1'b0;
    end
    else
    begin
      st_r      <= st_nxt;
      pcnt_r    <= pcnt_nxt;
      bcnt_r    <= bcnt_nxt;
      spec_r    <= spec_nxt;
      logged_r  <= ~clear & (logged_r | fire);
      ARMED     <= (st_nxt == stc_pkg::STC_S_SRCH1) | (st_nxt == stc_pkg::STC_S_SRCH2);
      LOGGING   <= st_nxt == stc_pkg::STC_S_LOG;
      TRIGGERED <= ~clear & (logged_r | fire);
      DROPPED   <= drop_set | (DROPPED & ~clear); // a drop in the clear cycle still shows
    end
  end

  // staging fifo; the store pauses draining while a read owns it
  stc_fifo #(
    .W (`STC_FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .flush     (clear),
    .in_valid  (f_in_v),
    .in_data   ({f_in_rst, ev_dir_r, ev_data_r}),
    .in_ready  (f_in_rdy),
    .out_valid (f_out_v),
    .out_data  (f_out_d),
    .out_ready (~RD_REQ),
    .full      (FIFO_FULL)
  );

  // drain into the store; writes past the data area are discarded
  wire       pop     = f_out_v & ~RD_REQ;
  wire       f_rst   = f_out_d[`STC_F_RST];
  wire [9:0] widx    = f_rst ? 10'h000 : wptr_r;
  wire       wr_en   = pop & ~clear & (widx < DB);
  wire [9:0] wptr_nxt = clear ? 10'h000 : (wr_en ? widx + 10'h001 : wptr_r);

  // write pointer and fill level
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wptr_r <= 10'h000;
      LEVEL  <= 10'h000;
      FULL   <= 1'b0;
    end
    else
    begin
      wptr_r <= wptr_nxt;
      LEVEL  <= wptr_nxt;
      FULL   <= wptr_nxt == DB;
    end
  end

  // data bytes and packed direction bits, eight per direction byte
  always_ff @(posedge CLK)
  begin
    if (wr_en)
    begin
      data_mem[widx] <= f_out_d[7:0];
      dir_mem[widx[9:3]][widx[2:0]] <= f_out_d[`STC_F_DIR];
    end
  end

  // readout by entry index, index zero is the oldest byte
  wire       rd_ok  = RD_IDX < wptr_r;
  wire [7:0] rd_d   = rd_ok ? data_mem[RD_IDX] : 8'h00;
  wire       rd_dir = rd_ok & dir_mem[RD_IDX[9:3]][RD_IDX[2:0]];

  // read answer one cycle after the request
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RD_VALID <= 1'b0;
      RD_HIT   <= 1'b0;
      RD_DATA  <= 8'h00;
      RD_DIR   <= 1'b0;
    end
    else
    begin
      RD_VALID <= RD_REQ;
      RD_HIT   <= RD_REQ & rd_ok;
      RD_DATA  <= rd_d;
      RD_DIR   <= rd_dir;
    end
  end

  // checks on the capture behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_full_level; FULL |-> LEVEL == `STC_DATA_BYTES; endproperty
  a_full_level: assert property (p_full_level) else $error("full without a full store");

  property p_dir_room; wr_en |-> widx[9:3] < DIR_BYTES; endproperty
  a_dir_room: assert property (p_dir_room) else $error("direction bit outside its area");

  property p_stop; FULL && !clear && !(pop && f_rst) |=> $stable(LEVEL); endproperty
  a_stop: assert property (p_stop) else $error("store written after full");

  property p_log_all; st_r == stc_pkg::STC_S_LOG && ev_v_r && !FULL && !clear |-> f_in_v; endproperty
  a_log_all: assert property (p_log_all) else $error("link byte not staged while logging");

  property p_first; fire && !ph_pkt && !clear |-> f_in_v && f_in_rst; endproperty
  a_first: assert property (p_first) else $error("trigger byte not logged first");

  property p_load_arms; CFG_LOAD |=> ARMED && !TRIGGERED && LEVEL == 10'h000; endproperty
  a_load_arms: assert property (p_load_arms) else $error("load did not arm the search");

  property p_pkt_def; CFG_LOAD && !CFG_PKT_N_SET |=> pkt_n_r == CNT_W'(`STC_DEF_PKT_N); endproperty
  a_pkt_def: assert property (p_pkt_def) else $error("packet count default wrong");

  property p_byte_def; CFG_LOAD && !CFG_BYTE_M_SET |=> byte_m_r == CNT_W'(`STC_DEF_BYTE_M); endproperty
  a_byte_def: assert property (p_byte_def) else $error("byte count default wrong");

  property p_any_byte;
    srch && !ph_pkt && !val_en_r && ev_v_r && !met && !clear |=> bcnt_r == $past(bcnt_r) + CNT_W'(1);
  endproperty
  a_any_byte: assert property (p_any_byte) else $error("byte not counted");

  property p_pb_order; $rose(TRIGGERED) && m_pb |-> $past(st_r) == stc_pkg::STC_S_SRCH2; endproperty
  a_pb_order: assert property (p_pb_order) else $error("fired before packet phase met");

  property p_bp_order; $rose(TRIGGERED) && m_bp |-> $past(st_r) == stc_pkg::STC_S_SRCH2; endproperty
  a_bp_order: assert property (p_bp_order) else $error("fired before byte phase met");

  property p_off; CMD_OFF && !clear |=> !ARMED && !LOGGING && $stable(TRIGGERED); endproperty
  a_off: assert property (p_off) else $error("off did not stop tracing");

  property p_on;
    CMD_ON && !CMD_OFF && !clear && st_r == stc_pkg::STC_S_OFF && logged_r && !FULL |=> LOGGING;
  endproperty
  a_on: assert property (p_on) else $error("on did not resume logging");

  property p_reset; CMD_RESET && !CFG_LOAD |=> ARMED && !TRIGGERED && LEVEL == 10'h000; endproperty
  a_reset: assert property (p_reset) else $error("reset did not erase and re-arm");
endmodule : stc_top

// *** tb/stc_host_model.sv ***
// host side of the serial link for the capture bench
`timescale 1ns/1ps
module stc_host_model (
  // clock
  input  wire logic  clk,
  // bytes on the link
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       tx_valid,
  output logic [7:0] tx_data,
  // framing of received packets
  output logic       pkt_sof,
  output logic       pkt_eop,
  output logic [7:0] pkt_opcode
);
  // idle link at time zero
  initial
  begin
    {rx_valid, tx_valid, pkt_sof, pkt_eop} = 4'h0;
    {rx_data, tx_data, pkt_opcode} = 24'h0;
  end

  // one byte in one cycle; lines scrambled after release so stale data never looks valid
  task automatic send(input logic dir, input logic [7:0] d, input logic s, input logic e, input logic [7:0] o);
    @(posedge clk);
    rx_valid   <= !dir;
    tx_valid   <= dir;
    rx_data    <= d;
    tx_data    <= d;
    pkt_sof    <= s & !dir;
    pkt_eop    <= e & !dir;
    pkt_opcode <= o;
    @(posedge clk);
    {rx_valid, tx_valid, pkt_sof, pkt_eop} <= 4'h0;
    rx_data    <= ~d;
    tx_data    <= ~d;
    pkt_opcode <= ~o;
  endtask : send

  // one received and one transmitted byte in the same cycle, so the tx byte must wait
  task automatic send_both(input logic [7:0] r, input logic [7:0] t);
    @(posedge clk);
    {rx_valid, tx_valid} <= 2'h3;
    rx_data <= r;
    tx_data <= t;
    @(posedge clk);
    {rx_valid, tx_valid} <= 2'h0;
    rx_data <= ~r;
    tx_data <= ~t;
  endtask : send_both
endmodule : stc_host_model

// *** tb/tb_top.sv ***
// self-checking bench for the serial trace capture block
`timescale 1ns/1ps
`define STC_CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  // design and partner wiring
  logic        clk, rst_n, rxv, txv, sof, eop, ld, ps, os, bs, vs, con, coff, crst, rdq;
  logic [7:0]  rxd, txd, opc, op, val, rdat;
  logic [1:0]  mode;
  logic [15:0] pn, bm;
  logic [9:0]  ridx, level;
  logic        rv, rhit, rdir, armed, lgo, trig, full, drop, ffull;
  // counters and reference model state
  int          err_count, checked, seed, md, mn, mm, ph, pc, bc, lg, act, oany, vany;
  logic [7:0]  mo, mv;
  logic [8:0]  exp_q[$], pbuf[$];

  stc_top stc_top_inst (
    .CLK(clk), .RST_N(rst_n), .RX_VALID(rxv), .RX_DATA(rxd), .TX_VALID(txv), .TX_DATA(txd),
    .PKT_SOF(sof), .PKT_EOP(eop), .PKT_OPCODE(opc), .CFG_LOAD(ld), .CFG_MODE(mode),
    .CFG_PKT_N_SET(ps), .CFG_PKT_N(pn), .CFG_OP_SET(os), .CFG_OP(op), .CFG_BYTE_M_SET(bs),
    .CFG_BYTE_M(bm), .CFG_VAL_SET(vs), .CFG_VAL(val), .CMD_ON(con), .CMD_OFF(coff),
    .CMD_RESET(crst), .RD_REQ(rdq), .RD_IDX(ridx), .RD_VALID(rv), .RD_HIT(rhit), .RD_DATA(rdat),
    .RD_DIR(rdir), .ARMED(armed), .LOGGING(lgo), .TRIGGERED(trig), .FULL(full), .LEVEL(level),
    .DROPPED(drop), .FIFO_FULL(ffull)
  );
  stc_host_model stc_host_model_inst (
    .clk(clk), .rx_valid(rxv), .rx_data(rxd), .tx_valid(txv), .tx_data(txd),
    .pkt_sof(sof), .pkt_eop(eop), .pkt_opcode(opc)
  );

  // free-running 100 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // model: empty store, search restarts
  task automatic clr();
    exp_q = {};
    pbuf = {};
    {lg, ph, pc, bc} = {32'h0, 32'h0, 32'h0, 32'h0};
    act = 1;
  endtask : clr

  // model: one link byte; packet bytes kept aside until their packet decides
  task automatic ev(input logic dir, input logic [7:0] d, input logic s, input logic e, input logic [7:0] o);
    int need;
    need = (md == 1) || (md == 2 && ph == 1) || (md == 3 && ph == 0);
    if (!act)
      return;
    if (lg)
    begin
      if (exp_q.size() < 910)
        exp_q.push_back({dir, d});
      return;
    end
    if (!dir && s)
      pbuf = {};
    if (!dir)
      pbuf.push_back({dir, d});
    if (need && (vany || d == mv))
    begin
      bc = bc + 1;
      if (bc >= mm && md == 3)
        ph = 1;
      else if (bc >= mm)
      begin
        lg = 1;
        exp_q = {};
        exp_q.push_back({dir, d});
      end
    end
    else if (!need && !dir && e && (oany || o == mo))
    begin
      pc = pc + 1;
      if (pc >= mn && md == 2)
        ph = 1;
      else if (pc >= mn)
      begin
        lg = 1;
        exp_q = pbuf;
      end
    end
  endtask : ev

  // one byte to model and device
  task automatic b(input logic dir, input logic [7:0] d, input logic s = 1'h0, input logic e = 1'h0,
                   input logic [7:0] o = 8'h00);
    ev(dir, d, s, e, o);
    stc_host_model_inst.send(dir, d, s, e, o);
  endtask : b

  // four-byte received packet
  task automatic pkt(input logic [7:0] o, input logic [7:0] base);
    for (int i = 0; i < 4; i++)
      b(1'h0, base + 8'(i), i == 0, i == 3, o);
  endtask : pkt

  task automatic rnd(input int n);
    for (int i = 0; i < n; i++)
      b(1'($random(seed)), 8'($random(seed)));
  endtask : rnd

  task automatic cfg(input int m, input logic p_s, input int n, input logic o_s, input logic [7:0] o,
                     input logic b_s, input int k, input logic v_s, input logic [7:0] v);
    @(posedge clk);
    ld   <= 1'h1;
    mode <= m[1:0];
    ps   <= p_s;
    pn   <= n[15:0];
    os   <= o_s;
    op   <= o;
    bs   <= b_s;
    bm   <= k[15:0];
    vs   <= v_s;
    val  <= v;
    @(posedge clk);
    ld <= 1'h0;
    md = m;
    mn = p_s ? n : 1;
    mm = b_s ? k : 4;
    oany = !o_s;
    vany = !v_s;
    mo = o;
    mv = v;
    clr();
    #1;
    `STC_CHK("armed", 1'h1, armed)
    `STC_CHK("triggered", 1'h0, trig)
  endtask : cfg

  // k: 0 on, 1 off, 2 reset
  task automatic cmd(input int k);
    @(posedge clk);
    con  <= (k == 0);
    coff <= (k == 1);
    crst <= (k == 2);
    @(posedge clk);
    {con, coff, crst} <= 3'h0;
    if (k == 2)
      clr();
    else
      act = (k == 0);
  endtask : cmd

  task automatic rd(input int i);
    @(posedge clk);
    rdq  <= 1'h1;
    ridx <= i[9:0];
    @(posedge clk);
    rdq <= 1'h0;
    #1;
    `STC_CHK("rd_valid", 1'h1, rv)
  endtask : rd

  // settle the pipeline, then compare status and every entry plus one past the end
  task automatic verify();
    repeat (8) @(posedge clk);
    #1;
    `STC_CHK("triggered", 1'h1, trig)
    `STC_CHK("logging", 1'(act && exp_q.size() < 910), lgo)
    `STC_CHK("full", 1'(exp_q.size() == 910), full)
    `STC_CHK("level", 10'(exp_q.size()), level)
    for (int i = 0; i <= exp_q.size(); i++)
    begin
      rd(i);
      `STC_CHK("hit", 1'(i < exp_q.size()), rhit)
      `STC_CHK("data", (i < exp_q.size()) ? exp_q[i][7:0] : 8'h00, rdat)
      if (i < exp_q.size())
        `STC_CHK("dir", exp_q[i][8], rdir)
    end
  endtask : verify

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // watchdog, well past the roughly 4000 cycles the tests need
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    seed = 53902;
    {rst_n, ld, ps, os, bs, vs, con, coff, crst, rdq} = 10'h0;
    {mode, op, val} = 18'h0;
    {pn, bm, ridx} = 42'h0;
    {md, mn, mm, act, lg} = {32'h0, 32'h1, 32'h4, 32'h0, 32'h0};
    repeat (8) @(posedge clk);
    #1;
    `STC_CHK("armed", 1'h0, armed)
    `STC_CHK("level", 10'h000, level)
    rst_n <= 1'h1;
    // second 2a in either direction fires
    cfg(1, 1, 1, 1'h0, 8'h00, 1'h1, 2, 1'h1, 8'h2a);
    b(1'h0, 8'h2a);
    b(1'h1, 8'h11);
    b(1'h1, 8'h2a);
    rnd(6);
    verify();
    // off keeps the store, on resumes
    cmd(1);
    rnd(3);
    verify();
    cmd(0);
    rnd(2);
    // rx and tx together: rx is logged first, then the held tx byte
    ev(1'h0, 8'hc3, 1'h0, 1'h0, 8'h00);
    ev(1'h1, 8'h3c, 1'h0, 1'h0, 8'h00);
    stc_host_model_inst.send_both(8'hc3, 8'h3c);
    verify();
    // reset empties and re-arms the same trigger
    cmd(2);
    #1;
    `STC_CHK("level", 10'h000, level)
    `STC_CHK("armed", 1'h1, armed)
    b(1'h1, 8'h2a);
    b(1'h0, 8'h2a);
    verify();
    // packet defaults: one packet, any opcode
    cfg(0, 1'h0, 9, 1'h0, 8'h00, 1'h0, 0, 1'h0, 8'h00);
    pkt(8'h33, 8'h80);
    b(1'h1, 8'h5a);
    verify();
    // two packets of opcode 07, another opcode ignored
    cfg(0, 1'h1, 2, 1'h1, 8'h07, 1'h0, 0, 1'h0, 8'h00);
    pkt(8'h05, 8'h10);
    pkt(8'h07, 8'h20);
    pkt(8'h07, 8'h30);
    verify();
    // packet then byte: an early 2a must not fire
    cfg(2, 1'h0, 0, 1'h0, 8'h00, 1'h1, 1, 1'h1, 8'h2a);
    b(1'h1, 8'h2a);
    pkt(8'h07, 8'h40);
    b(1'h1, 8'h2a);
    rnd(2);
    verify();
    // byte then packet: an early packet must not fire
    cfg(3, 1'h0, 0, 1'h0, 8'h00, 1'h1, 1, 1'h1, 8'h2a);
    pkt(8'h09, 8'h50);
    b(1'h0, 8'h2a);
    pkt(8'h09, 8'h60);
    verify();
    // reads stall the store until the staging fifo refuses, then it drains
    @(posedge clk);
    rdq <= 1'h1;
    for (int i = 0; i < 20; i++)
      stc_host_model_inst.send(1'h0, 8'(i), 1'h0, 1'h0, 8'h00);
    #1;
    `STC_CHK("fifo_full", 1'h1, ffull)
    `STC_CHK("dropped", 1'h1, drop)
    @(posedge clk);
    rdq <= 1'h0;
    repeat (40) @(posedge clk);
    #1;
    `STC_CHK("fifo_full", 1'h0, ffull)
    // default four bytes of any value, then overfill the store
    cfg(1, 1'h0, 0, 1'h0, 8'h00, 1'h0, 9, 1'h0, 8'h00);
    rnd(920);
    verify();
    tally_and_finish();
  end
endmodule : tb_top
